/* File: bztg_defs.svh */
`ifndef BZTG_DEFS_SVH
`define BZTG_DEFS_SVH

// register addresses on the byte register port
`define BZTG_ADDR_CTRL        16'hff94
`define BZTG_ADDR_VOL         16'hff95
`define BZTG_ADDR_PERIOD      16'hff96

// reset values
`define BZTG_RST_CTRL         8'h00
`define BZTG_RST_VOL          8'h00
`define BZTG_RST_PERIOD       8'h00

// tone_control field positions
`define BZTG_CTRL_RUN         7
`define BZTG_CTRL_OSEL        3
`define BZTG_CTRL_PRE_HI      2
`define BZTG_CTRL_PRE_LO      1
`define BZTG_CTRL_IN_SEL      0

// writable bits of each register, others read as zero
`define BZTG_MASK_CTRL        8'h8f
`define BZTG_MASK_VOL         8'h7f
`define BZTG_MASK_PERIOD      8'h0f

// tone counter reloads after period plus this many counts
`define BZTG_PERIOD_ADD       6'h11

// counter prescaler masks for division by 2^5 .. 2^8
`define BZTG_PRE_MASK_5       8'h1f
`define BZTG_PRE_MASK_6       8'h3f
`define BZTG_PRE_MASK_7       8'h7f
`define BZTG_PRE_MASK_8       8'hff

`endif

/* File: bztg_pkg.sv */
package bztg_pkg;

   // tone pin source
   typedef enum logic
   {
      BZTG_PLAIN,
      BZTG_GATED
   } bztg_omode_t;

   // counter prescaler code, bits high:low
   typedef logic [1:0] bztg_pre_t;

endpackage

/* File: bztg_pwm.sv */
`timescale 1ns/1ns
`include "bztg_defs.svh"

module bztg_pwm
#(
   parameter int RES = 7                 // amplitude resolution in bits
)
(
   input  wire logic           clock,    // system clock
   input  wire logic           nrst,     // synchronous reset, active low
   input  wire logic           run,      // generator running
   input  wire logic           step,     // tone input frequency enable
   input  wire logic [RES-1:0] level,    // amplitude field
   output logic                pwm_out   // registered amplitude waveform
);

   logic [RES-1:0] cnt_r;
   logic [RES-1:0] cnt_nxt;
   logic           out_r;
   logic           out_nxt;

   // phase counter and comparator, level read live
   always_comb
   begin
      cnt_nxt = cnt_r;
      out_nxt = 1'b0;
      if (run)
      begin
         if (step)
            cnt_nxt = cnt_r + 1'b1;
         // zero gives nothing, n gives n+1 of 2^RES steps
         out_nxt = (level != '0) && (cnt_r <= level);
      end
      else
         cnt_nxt = '0;
   end

   // state registers
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         cnt_r <= '0;
         out_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         out_r <= out_nxt;
      end
   end

   assign pwm_out = out_r;

   chk_pwm_zero_low: assert property (@(posedge clock) disable iff (!nrst)
      level == '0 |=> !pwm_out)
      else $error("amplitude high with zero level");

   chk_pwm_full_high: assert property (@(posedge clock) disable iff (!nrst)
      run && level == '1 |=> pwm_out)
      else $error("amplitude low at full level");

   chk_pwm_stop_clr: assert property (@(posedge clock) disable iff (!nrst)
      !run |=> cnt_r == '0 && !pwm_out)
      else $error("amplitude counter not cleared when stopped");

endmodule

/* File: bztg_spk.sv */
`timescale 1ns/1ns

module bztg_spk
(
   input  wire logic        clock,   // system clock
   input  wire logic        clr,     // restart the counts
   input  wire logic        tone_in, // tone pin level
   input  wire logic        amp_in,  // amplitude pin level
   input  wire logic        amp_rel, // amplitude pin used elsewhere
   output logic      [15:0] tone_hi, // cycles heard high on tone pin
   output logic      [15:0] amp_hi   // cycles heard high on amp pin
);
   // speaker integrates what it receives on each pin
   always_ff @(posedge clock)
   begin
      if (clr)
      begin
         tone_hi <= 16'h0000;
         amp_hi  <= 16'h0000;
      end
      else
      begin
         tone_hi <= tone_hi + {15'h0000, tone_in};
         amp_hi  <= amp_hi + {15'h0000, amp_in & ~amp_rel};
      end
   end
endmodule

/* File: bztg_top.sv */
// How it works
// - with the run bit clear the tone timer stops and the tone and amp pins sit low.
// - with the run bit set the generator runs and drives its waveforms.
// - output_select 0 puts the plain tone and the amplitude pwm on pins.
// - output_select 1 puts the gated tone on the tone pin, frees amp pin.
// - input_prescale_select picks half the clock (0) or full clock (1).
// - the prescale code divides the input rate by 2^5, 2^6, 2^7 or 2^8.
// - tone frequency is fx/(period+17) times 2^(s0-s1-2*s2-7).
// - amplitude 0 gives duty 0/128, any other n gives (n+1)/128.
// - the gated tone is the square wave ANDed with the amplitude pwm.
// - volume_level may be rewritten while running, without a stop.
// - reset clears all three registers to zero.
// - in plain mode the amplitude pwm runs on its pin alongside the tone.
`timescale 1ns/1ns
`include "bztg_defs.svh"

module bztg_top
(
   input  wire logic        clock,       // system clock fx, 50 MHz
   input  wire logic        nrst,        // synchronous reset, active low
   input  wire logic [15:0] reg_addr,    // register byte address
   input  wire logic [7:0]  reg_wdata,   // write data
   input  wire logic        reg_wr,      // write strobe, one cycle
   input  wire logic        reg_rd,      // read strobe, one cycle
   output logic      [7:0]  reg_rdata,   // read data, one cycle later
   output logic             tone_out,    // tone pin, plain or gated
   output logic             amp_out,     // amplitude pwm pin
   output logic             amp_release  // amp pin handed to other use
);

   logic [7:0] ctrl_r;
   logic [7:0] ctrl_nxt;
   logic [7:0] vol_r;
   logic [7:0] vol_nxt;
   logic [7:0] period_r;
   logic [7:0] period_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   logic                 run;
   bztg_pkg::bztg_omode_t omode;
   bztg_pkg::bztg_pre_t  pre_code;
   logic                 in_sel;

   logic       div_r;
   logic       div_nxt;
   logic       in_en;
   logic [7:0] pre_r;
   logic [7:0] pre_nxt;
   logic       cnt_en;
   logic [4:0] tone_cnt_r;
   logic [4:0] tone_cnt_nxt;
   logic [5:0] tone_limit;
   logic       tone_sq_r;
   logic       tone_sq_nxt;
   logic       pwm_lvl;

   logic       tone_r;
   logic       tone_nxt;
   logic       amp_r;
   logic       amp_nxt;
   logic       rel_r;
   logic       rel_nxt;

   // prescaler mask for the chosen division
   function automatic logic [7:0] pre_mask(input bztg_pkg::bztg_pre_t code);
      logic [7:0] m;
      m = `BZTG_PRE_MASK_5;
      unique case (code)
         2'h0: m = `BZTG_PRE_MASK_5;
         2'h1: m = `BZTG_PRE_MASK_6;
         2'h2: m = `BZTG_PRE_MASK_7;
         2'h3: m = `BZTG_PRE_MASK_8;
      endcase
      return m;
   endfunction

   // control field decode
   assign run      = ctrl_r[`BZTG_CTRL_RUN];
   assign omode    = ctrl_r[`BZTG_CTRL_OSEL] ? bztg_pkg::BZTG_GATED
                                             : bztg_pkg::BZTG_PLAIN;
   assign pre_code = {ctrl_r[`BZTG_CTRL_PRE_HI], ctrl_r[`BZTG_CTRL_PRE_LO]};
   assign in_sel   = ctrl_r[`BZTG_CTRL_IN_SEL];

   // register writes and read data
   always_comb
   begin
      ctrl_nxt   = ctrl_r;
      vol_nxt    = vol_r;
      period_nxt = period_r;
      rdata_nxt  = 8'h00;
      if (reg_wr)
      begin
         unique case (reg_addr)
            `BZTG_ADDR_CTRL:   ctrl_nxt   = reg_wdata & `BZTG_MASK_CTRL;
            `BZTG_ADDR_VOL:    vol_nxt    = reg_wdata & `BZTG_MASK_VOL;
            `BZTG_ADDR_PERIOD: period_nxt = reg_wdata & `BZTG_MASK_PERIOD;
            default:           ;
         endcase
      end
      if (reg_rd)
      begin
         unique case (reg_addr)
            `BZTG_ADDR_CTRL:   rdata_nxt = ctrl_r;
            `BZTG_ADDR_VOL:    rdata_nxt = vol_r;
            `BZTG_ADDR_PERIOD: rdata_nxt = period_r;
            default:           rdata_nxt = 8'h00;
         endcase
      end
   end

   // register file
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         ctrl_r   <= `BZTG_RST_CTRL;
         vol_r    <= `BZTG_RST_VOL;
         period_r <= `BZTG_RST_PERIOD;
         rdata_r  <= 8'h00;
      end
      else
      begin
         ctrl_r   <= ctrl_nxt;
         vol_r    <= vol_nxt;
         period_r <= period_nxt;
         rdata_r  <= rdata_nxt;
      end
   end

   // input rate enable: every cycle or every other one
   assign in_en = run && (in_sel || div_r);

   // counter clock enable after 2^(5+code) input steps
   assign cnt_en = in_en &&
                   ((pre_r & pre_mask(pre_code)) == pre_mask(pre_code));

   // tone counter runs 0 .. period+16, i.e. period+17 counts
   assign tone_limit = {2'h0, period_r[3:0]} + `BZTG_PERIOD_ADD - 6'h01;

   // dividers, tone counter and square wave
   always_comb
   begin
      div_nxt      = 1'b0;
      pre_nxt      = 8'h00;
      tone_cnt_nxt = 5'h00;
      tone_sq_nxt  = 1'b0;
      if (run)
      begin
         div_nxt      = ~div_r;
         pre_nxt      = in_en ? pre_r + 8'h01 : pre_r;
         tone_cnt_nxt = tone_cnt_r;
         tone_sq_nxt  = tone_sq_r;
         if (cnt_en)
         begin
            if ({1'b0, tone_cnt_r} == tone_limit)
            begin
               tone_cnt_nxt = 5'h00;
               tone_sq_nxt  = ~tone_sq_r;
            end
            else
               tone_cnt_nxt = tone_cnt_r + 5'h01;
         end
      end
   end

   // timing state registers
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         div_r      <= 1'b0;
         pre_r      <= 8'h00;
         tone_cnt_r <= 5'h00;
         tone_sq_r  <= 1'b0;
      end
      else
      begin
         div_r      <= div_nxt;
         pre_r      <= pre_nxt;
         tone_cnt_r <= tone_cnt_nxt;
         tone_sq_r  <= tone_sq_nxt;
      end
   end

   // amplitude pwm on the tone input rate
   bztg_pwm #(.RES(7)) u_pwm
   (
      .clock   (clock),
      .nrst    (nrst),
      .run     (run),
      .step    (in_en),
      .level   (vol_r[6:0]),
      .pwm_out (pwm_lvl)
   );

   // pin selection
   always_comb
   begin
      tone_nxt = 1'b0;
      amp_nxt  = 1'b0;
      rel_nxt  = (omode == bztg_pkg::BZTG_GATED);
      if (run)
      begin
         unique case (omode)
            bztg_pkg::BZTG_PLAIN:
            begin
               tone_nxt = tone_sq_r;
               amp_nxt  = pwm_lvl;
            end
            bztg_pkg::BZTG_GATED:
            begin
               tone_nxt = tone_sq_r & pwm_lvl;
               amp_nxt  = 1'b0;
            end
         endcase
      end
   end

   // output registers
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         tone_r <= 1'b0;
         amp_r  <= 1'b0;
         rel_r  <= 1'b0;
      end
      else
      begin
         tone_r <= tone_nxt;
         amp_r  <= amp_nxt;
         rel_r  <= rel_nxt;
      end
   end

   assign reg_rdata   = rdata_r;
   assign tone_out    = tone_r;
   assign amp_out     = amp_r;
   assign amp_release = rel_r;

   chk_stop_low: assert property (@(posedge clock) disable iff (!nrst)
      !run |=> !tone_out && !amp_out)
      else $error("outputs not low while stopped");

   chk_reset_regs: assert property (@(posedge clock)
      !nrst |=> ctrl_r == 8'h00 && vol_r == 8'h00 && period_r == 8'h00)
      else $error("registers not cleared by reset");

   chk_plain_pins: assert property (@(posedge clock) disable iff (!nrst)
      run && omode == bztg_pkg::BZTG_PLAIN
      |=> tone_out == $past(tone_sq_r) && amp_out == $past(pwm_lvl))
      else $error("plain mode pins wrong");

   chk_gated_and: assert property (@(posedge clock) disable iff (!nrst)
      run && omode == bztg_pkg::BZTG_GATED
      |=> tone_out == ($past(tone_sq_r) && $past(pwm_lvl)) && !amp_out)
      else $error("gated tone not the AND of tone and pwm");

   chk_amp_release: assert property (@(posedge clock) disable iff (!nrst)
      ctrl_r[`BZTG_CTRL_OSEL] |=> amp_release)
      else $error("amplitude pin not released in gated mode");

   chk_half_rate: assert property (@(posedge clock) disable iff (!nrst)
      run && !in_sel && in_en && $stable(ctrl_r) |=> !in_en)
      else $error("half rate input enable fired twice in a row");

   chk_tone_bound: assert property (@(posedge clock) disable iff (!nrst)
      {1'b0, tone_cnt_r} <= tone_limit)
      else $error("tone counter passed its reload value");

   chk_tone_toggle: assert property (@(posedge clock) disable iff (!nrst)
      run && cnt_en && {1'b0, tone_cnt_r} == tone_limit && $stable(ctrl_r)
      |=> tone_sq_r != $past(tone_sq_r) && tone_cnt_r == 5'h00)
      else $error("square wave did not toggle at reload");

   chk_pre_step: assert property (@(posedge clock) disable iff (!nrst)
      cnt_en |-> (pre_r[4:0] == 5'h1f) && in_en)
      else $error("counter enable without full prescale");

   // timer state, input rate and pin ownership
   chk_timer_clr: assert property (@(posedge clock) disable iff (!nrst)
      !run |=> tone_cnt_r == 5'h00 && !tone_sq_r && pre_r == 8'h00)
      else $error("tone timer not cleared while stopped");

   chk_full_rate: assert property (@(posedge clock) disable iff (!nrst)
      run && in_sel |=> pre_r == $past(pre_r) + 8'h01)
      else $error("full rate prescaler missed a step");

   chk_plain_own: assert property (@(posedge clock) disable iff (!nrst)
      !ctrl_r[`BZTG_CTRL_OSEL] |=> !amp_release)
      else $error("amplitude pin released in plain mode");

   chk_gated_amp: assert property (@(posedge clock) disable iff (!nrst)
      omode == bztg_pkg::BZTG_GATED |=> !amp_out)
      else $error("amplitude pin driven in gated mode");

   chk_sq_hold: assert property (@(posedge clock) disable iff (!nrst)
      run && !cnt_en |=> tone_sq_r == $past(tone_sq_r))
      else $error("square wave moved between counter steps");

endmodule

/* File: bztg_top_tb.sv */
`timescale 1ns/1ns
`include "bztg_defs.svh"

module bztg_top_tb;
   logic        clock;
   logic        nrst;
   logic [15:0] reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_rdata;
   logic        tone_out;
   logic        amp_out;
   logic        amp_release;
   logic        clr;
   logic [15:0] tone_hi;
   logic [15:0] amp_hi;
   logic [7:0]  v;
   logic [7:0]  e;
   int          fails;
   int          checks_done;
   int          k;
   int          lv;
   logic [15:0] ad [3] = '{`BZTG_ADDR_CTRL, `BZTG_ADDR_VOL, `BZTG_ADDR_PERIOD};
   logic [7:0]  mk [3] = '{`BZTG_MASK_CTRL, `BZTG_MASK_VOL, `BZTG_MASK_PERIOD};

   bztg_top u_dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .tone_out(tone_out), .amp_out(amp_out),
      .amp_release(amp_release));

   bztg_spk u_spk (.clock(clock), .clr(clr), .tone_in(tone_out),
      .amp_in(amp_out), .amp_rel(amp_release), .tone_hi(tone_hi),
      .amp_hi(amp_hi));

   // system clock, 20 ns
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // expected tone half period in clock cycles
   function automatic int half_cyc(input int per, input int code,
                                   input logic full);
      return (per + 17) * (32 << code) * (full ? 1 : 2);
   endfunction

   // expected high cycles of the amplitude pwm over a window
   function automatic logic [15:0] duty(input int lvl, input int win);
      return (lvl == 0) ? 16'h0000 : 16'((lvl + 1) * win / 128);
   endfunction

   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] seen);
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // one byte register write, strobe held one edge
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr    <= 1'b0;
   endtask

   // one byte register read, data taken the cycle after the strobe
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // bounded wait for the tone pin to reach a level
   task automatic wait_tone(input logic lvl, input int lim, output int cyc);
      cyc = 0;
      while (tone_out !== lvl)
      begin
         @(posedge clock);
         #1 cyc++;
         if (cyc > lim)
         begin
            chk("tone edge timeout", 16'(lim), 16'(cyc));
            results();
         end
      end
   endtask

   // clear the speaker counts, then listen for w cycles
   task automatic listen(input int w);
      @(posedge clock);
      clr <= 1'b1;
      @(posedge clock);
      clr <= 1'b0;
      repeat (w) @(posedge clock);
      #1;
   endtask

   // clear only the run bit, leaving the other fields as they stand
   task automatic halt();
      logic [7:0] c;
      rd(`BZTG_ADDR_CTRL, c);
      wr(`BZTG_ADDR_CTRL, c & 8'h7f);
   endtask

   // stop, program, start, then time both halves of the tone
   task automatic tone_run(input logic [7:0] f, input int per);
      int h;
      int t;
      h = half_cyc(per, int'(f[2:1]), f[0]);
      halt();
      wr(`BZTG_ADDR_CTRL, f);
      wr(`BZTG_ADDR_PERIOD, 8'(per));
      wr(`BZTG_ADDR_CTRL, f | 8'h80);
      wait_tone(1'b1, 2 * h + 8, t);
      wait_tone(1'b0, h + 8, t);
      chk("tone high time", 16'(h), 16'(t));
      wait_tone(1'b1, h + 8, t);
      chk("tone low time", 16'(h), 16'(t));
      $display("test tone %h period %0d done", f, per);
   endtask

   // main sequence
   initial
   begin
      nrst      = 1'b0;
      reg_addr  = 16'h0000;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      clr       = 1'b1;
      fails     = 0;
      checks_done = 0;
      void'($urandom(32'haab3));
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      #1 chk("tone after reset", 16'h0000, 16'(tone_out));
      for (k = 0; k < 3; k++)
      begin
         rd(ad[k], v);
         chk("reset value", 16'h0000, 16'(v));
         e = 8'($urandom) & mk[k] & 8'h7f; // unused bits and run kept 0
         wr(ad[k], e);
         rd(ad[k], v);
         chk("stored value", 16'(e), 16'(v));
         wr(ad[k], 8'h00);
      end
      wr(16'hff97, 8'h55);
      rd(16'hff97, v);
      chk("unmapped read", 16'h0000, 16'(v));
      $display("test registers done");
      // each prescale code and both input rates
      tone_run(8'h01, int'($urandom % 16));
      tone_run(8'h03, int'($urandom % 16));
      tone_run(8'h05, 0);
      tone_run(8'h07, 0);
      tone_run(8'h00, int'($urandom % 16));
      tone_run(8'h01, 15);
      // amplitude rewrites while the generator runs
      for (k = 0; k < 6; k++)
      begin
         lv = (k == 0) ? 0 : (k == 1) ? 1 : (k == 2) ? 127
            : int'($urandom % 128);
         wr(`BZTG_ADDR_VOL, 8'(lv));
         repeat (140) @(posedge clock);
         listen(2048);
         chk("amp duty", duty(lv, 2048), amp_hi);
         chk("amp pin owned", 16'h0000, 16'(amp_release));
         chk("tone in window", 16'(half_cyc(15, 0, 1'b1)), tone_hi);
      end
      $display("test amplitude done");
      // gated tone at full volume matches the plain square wave
      wr(`BZTG_ADDR_VOL, 8'h7f);
      tone_run(8'h09, 15);
      chk("amp pin released", 16'h0001, 16'(amp_release));
      chk("amp pin low", 16'h0000, 16'(amp_out));
      // gated tone at zero volume stays silent
      wr(`BZTG_ADDR_VOL, 8'h00);
      repeat (140) @(posedge clock);
      listen(2048);
      chk("gated silent", 16'h0000, tone_hi);
      $display("test gated done");
      // stopping holds the tone and amp pins low
      wr(`BZTG_ADDR_VOL, 8'h40);
      halt();
      wr(`BZTG_ADDR_CTRL, 8'h01);
      wr(`BZTG_ADDR_CTRL, 8'h81);
      repeat (300) @(posedge clock);
      wr(`BZTG_ADDR_CTRL, 8'h01);
      repeat (2) @(posedge clock);
      listen(1200);
      chk("stopped tone", 16'h0000, tone_hi);
      chk("stopped amp", 16'h0000, amp_hi);
      $display("test stop done");
      results();
   end
endmodule
